// >>> core/ksf_pkg.sv
// Purpose: constants shared by the sequencer / fec / negotiation register bank
// Assumes: word-addressed management port, 32-bit data
// Notes: offsets are word indices as printed
package ksf_pkg;

  // ----------------------------------------------------------------
  // word addresses
  // ----------------------------------------------------------------
  localparam logic [10:0] KSF_ADDR_SEQ_CTRL = 11'h4B0;
  localparam logic [10:0] KSF_ADDR_SEQ_STAT = 11'h4B1;
  localparam logic [10:0] KSF_ADDR_FEC_INJ = 11'h4B2;
  localparam logic [10:0] KSF_ADDR_RSVD_LO = 11'h4B5;
  localparam logic [10:0] KSF_ADDR_RSVD_HI = 11'h4BF;
  localparam logic [10:0] KSF_ADDR_AN_CTRL = 11'h4C0;
  localparam logic [10:0] KSF_ADDR_AN_CMD = 11'h4C1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int KSF_SC_RESET_SEQ = 0;
  localparam int KSF_SC_FEC_EN = 16;
  localparam int KSF_SC_FEC_ERR_IND = 17;
  localparam int KSF_SC_FEC_REQ = 18;
  localparam int KSF_ST_LINK_READY = 0;
  localparam int KSF_ST_AN_TMO = 1;
  localparam int KSF_ST_LT_TMO = 2;
  localparam int KSF_ST_MODE_LSB = 8;
  localparam int KSF_ST_MODE_W = 6;
  localparam int KSF_ST_FEC_ABLE = 16;
  localparam int KSF_ST_ERR_IND_ABLE = 17;
  localparam int KSF_FI_INJECT = 11;
  localparam int KSF_AC_AN_EN = 0;
  localparam int KSF_AC_USER_BASE = 1;
  localparam int KSF_AC_USER_NEXT = 2;
  localparam int KSF_AC_REM_FAULT = 3;
  localparam int KSF_AC_FORCE_NONCE = 4;
  localparam int KSF_AC_OVERRIDE = 5;
  localparam int KSF_CMD_RESET_AN = 0;
  localparam int KSF_CMD_RESTART_TX = 4;
  localparam int KSF_CMD_NEXT_PAGE = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic KSF_AN_EN_RESET = 1'b1;
  localparam logic [31:0] KSF_ZERO_WORD = 32'h0000_0000;

endpackage : ksf_pkg

// >>> core/ksf_pulse.sv
// Purpose: self-clearing command bit, one-cycle action pulse
// Assumes: write strobe and data synchronous to clk
// Notes: optional qualifier gates whether the pulse is issued
module ksf_pulse (
  input wire logic clk,
  input wire logic reset,
  input wire logic set_req,
  input wire logic allow,
  output logic pulse
);
  import ksf_pkg::*;

  // ----------------------------------------------------------------
  // pulse register
  // ----------------------------------------------------------------
  // one cycle high per accepted write of 1, then back to 0
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse <= 1'b0;
    end else begin
      pulse <= set_req & allow;
    end
  end
endmodule : ksf_pulse

// >>> core/ksf_status_hold.sv
// Purpose: sticky status flag with priority to a new event
// Assumes: event and clear are one-cycle or level signals on clk
// Notes: set wins over clear in the same cycle
module ksf_status_hold (
  input wire logic clk,
  input wire logic reset,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag
);
  import ksf_pkg::*;

  // ----------------------------------------------------------------
  // sticky flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set_evt) begin
      flag <= 1'b1;
    end else if (clr_evt) begin
      flag <= 1'b0;
    end
  end
endmodule : ksf_status_hold

// >>> core/ksf_regs.sv
// Purpose: sequencer, fec and auto-negotiation control/status register bank
// Assumes: word-addressed management port, reads answered one cycle later
// Notes: self-clearing command bits emit one-cycle pulses to the engines; next page bit 8 is held until sent or command bit 0 resets negotiation
//
// Notes on behaviour
// - fec enable bit 16 switches fec; reset value from default parameter
// - bit 17 chooses whether fec decode errors go to the pcs
// - bit 18 drives fec request; software pulses sequencer reset after change
// - status bit 0 shows sequencer link ready
// - status bit 1 latches negotiation timeout, cleared on negotiation restart
// - status bit 2 shows link training timeout
// - status bits 13:8 show one-hot pcs reconfiguration mode
// - status bit 16 shows fec support from build parameter
// - status bit 17 shows fec error reporting ability
// - inject bit 11 sends one tx fec error pulse, then clears
// - negotiation enable bit 0, defaults to 1
// - bit 1 selects user base pages over generated ones
// - bit 2 selects user next pages over null messages
// - bit 3 signals remote fault in transmitted pages
// - bit 4 forces the transmitted nonce for conformance tests
// - bit 5 substitutes override advertisement; software then resets sequencer
// - command bit 0 resets all negotiation machines, then clears
// - command bit 4 restarts tx machine only in negotiation state, clears
// - command bit 8 sends loaded next page once, then clears
// - sequencer control bit 0 resets sequencer and reruns negotiation, clears
module ksf_regs #(
  parameter bit FEC_DEFAULT_PARAM = 1'b1,
  parameter bit FEC_BUILD_PARAM = 1'b1,
  parameter bit ERR_IND_ABLE = 1'b1,
  parameter int ADDR_W = 11
) (
  input wire logic clk,
  input wire logic reset,
  // management port
  input wire logic [ADDR_W-1:0] mgmt_address,
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  input wire logic [31:0] mgmt_writedata,
  output logic [31:0] mgmt_readdata,
  output logic mgmt_readvalid,
  // sequencer side
  input wire logic seq_link_ready,
  input wire logic negotiation_timeout_flag_evt,
  input wire logic seq_an_restart_evt,
  input wire logic training_timeout_flag,
  input wire logic [ksf_pkg::KSF_ST_MODE_W-1:0] seq_reconfig_mode,
  input wire logic tx_sm_in_an_state,
  input wire logic next_page_sent,
  // controls to the engines
  output logic fec_enable,
  output logic fec_err_to_pcs,
  output logic fec_request_enable,
  output logic seq_reset_pulse,
  output logic tx_fec_error_pulse,
  output logic an_enable,
  output logic user_base_page_sel,
  output logic user_next_page_sel,
  output logic local_remote_fault,
  output logic force_tx_nonce,
  output logic override_adv_enable,
  output logic an_reset_pulse,
  output logic an_tx_restart_pulse,
  output logic extended_next_page_ready
);
  import ksf_pkg::*;

  // refuse an address port too narrow for the word map
  if (ADDR_W < 11) begin : g_bad_addr_w
    $error("ksf_regs: ADDR_W must be at least 11");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic wr_seq_ctrl;
  logic wr_fec_inj;
  logic wr_an_ctrl;
  logic wr_an_cmd;
  logic an_timeout_flag;
  logic next_page_clr;
  logic [31:0] next_readdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [10:0] w);
    hit = (a == ADDR_W'(w));
  endfunction : hit

  assign wr_seq_ctrl = mgmt_write & hit(mgmt_address, KSF_ADDR_SEQ_CTRL);
  assign wr_fec_inj = mgmt_write & hit(mgmt_address, KSF_ADDR_FEC_INJ);
  assign wr_an_ctrl = mgmt_write & hit(mgmt_address, KSF_ADDR_AN_CTRL);
  assign wr_an_cmd = mgmt_write & hit(mgmt_address, KSF_ADDR_AN_CMD);

  // ----------------------------------------------------------------
  // sequencer / fec control word
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      fec_enable <= FEC_DEFAULT_PARAM;
      fec_err_to_pcs <= 1'b0;
      fec_request_enable <= 1'b0;
    end else if (wr_seq_ctrl) begin
      fec_enable <= mgmt_writedata[KSF_SC_FEC_EN];
      fec_err_to_pcs <= mgmt_writedata[KSF_SC_FEC_ERR_IND];
      fec_request_enable <= mgmt_writedata[KSF_SC_FEC_REQ];
    end
  end

  // sequencer reset: one pulse, bit reads back 0
  ksf_pulse u_seq_reset (
    .clk(clk),
    .reset(reset),
    .set_req(wr_seq_ctrl & mgmt_writedata[KSF_SC_RESET_SEQ]),
    .allow(1'b1),
    .pulse(seq_reset_pulse)
  );

  // tx fec error injection pulse
  ksf_pulse u_fec_inject (
    .clk(clk),
    .reset(reset),
    .set_req(wr_fec_inj & mgmt_writedata[KSF_FI_INJECT]),
    .allow(1'b1),
    .pulse(tx_fec_error_pulse)
  );

  // ----------------------------------------------------------------
  // sequencer status
  // ----------------------------------------------------------------
  // negotiation timeout is sticky until the sequencer restarts negotiation
  ksf_status_hold u_an_tmo (
    .clk(clk),
    .reset(reset),
    .set_evt(negotiation_timeout_flag_evt),
    .clr_evt(seq_an_restart_evt),
    .flag(an_timeout_flag)
  );

  // ----------------------------------------------------------------
  // auto-negotiation control word
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      an_enable <= KSF_AN_EN_RESET;
      user_base_page_sel <= 1'b0;
      user_next_page_sel <= 1'b0;
      local_remote_fault <= 1'b0;
      force_tx_nonce <= 1'b0;
      override_adv_enable <= 1'b0;
    end else if (wr_an_ctrl) begin
      an_enable <= mgmt_writedata[KSF_AC_AN_EN];
      user_base_page_sel <= mgmt_writedata[KSF_AC_USER_BASE];
      user_next_page_sel <= mgmt_writedata[KSF_AC_USER_NEXT];
      local_remote_fault <= mgmt_writedata[KSF_AC_REM_FAULT];
      force_tx_nonce <= mgmt_writedata[KSF_AC_FORCE_NONCE];
      override_adv_enable <= mgmt_writedata[KSF_AC_OVERRIDE];
    end
  end

  // ----------------------------------------------------------------
  // auto-negotiation command word
  // ----------------------------------------------------------------
  ksf_pulse u_an_reset (
    .clk(clk),
    .reset(reset),
    .set_req(wr_an_cmd & mgmt_writedata[KSF_CMD_RESET_AN]),
    .allow(1'b1),
    .pulse(an_reset_pulse)
  );

  // restart only honoured while the tx machine sits in negotiation
  ksf_pulse u_tx_restart (
    .clk(clk),
    .reset(reset),
    .set_req(wr_an_cmd & mgmt_writedata[KSF_CMD_RESTART_TX]),
    .allow(tx_sm_in_an_state),
    .pulse(an_tx_restart_pulse)
  );

  // next page request held until the engine reports it sent or an_reset_pulse fires
  assign next_page_clr = next_page_sent | an_reset_pulse;

  always_ff @(posedge clk) begin
    if (reset) begin
      extended_next_page_ready <= 1'b0;
    end else if (wr_an_cmd & mgmt_writedata[KSF_CMD_NEXT_PAGE]) begin
      extended_next_page_ready <= 1'b1;
    end else if (next_page_clr) begin
      extended_next_page_ready <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_readdata = KSF_ZERO_WORD;
    if (hit(mgmt_address, KSF_ADDR_SEQ_CTRL)) begin
      next_readdata[KSF_SC_FEC_EN] = fec_enable;
      next_readdata[KSF_SC_FEC_ERR_IND] = fec_err_to_pcs;
      next_readdata[KSF_SC_FEC_REQ] = fec_request_enable;
    end else if (hit(mgmt_address, KSF_ADDR_SEQ_STAT)) begin
      next_readdata[KSF_ST_LINK_READY] = seq_link_ready;
      next_readdata[KSF_ST_AN_TMO] = an_timeout_flag;
      next_readdata[KSF_ST_LT_TMO] = training_timeout_flag;
      next_readdata[KSF_ST_MODE_LSB +: KSF_ST_MODE_W] = seq_reconfig_mode;
      next_readdata[KSF_ST_FEC_ABLE] = FEC_BUILD_PARAM;
      next_readdata[KSF_ST_ERR_IND_ABLE] = ERR_IND_ABLE;
    end else if (hit(mgmt_address, KSF_ADDR_AN_CTRL)) begin
      next_readdata[KSF_AC_AN_EN] = an_enable;
      next_readdata[KSF_AC_USER_BASE] = user_base_page_sel;
      next_readdata[KSF_AC_USER_NEXT] = user_next_page_sel;
      next_readdata[KSF_AC_REM_FAULT] = local_remote_fault;
      next_readdata[KSF_AC_FORCE_NONCE] = force_tx_nonce;
      next_readdata[KSF_AC_OVERRIDE] = override_adv_enable;
    end else if (hit(mgmt_address, KSF_ADDR_AN_CMD)) begin
      next_readdata[KSF_CMD_NEXT_PAGE] = extended_next_page_ready;
    end
  end

  // registered read answer, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      mgmt_readdata <= KSF_ZERO_WORD;
      mgmt_readvalid <= 1'b0;
    end else begin
      mgmt_readvalid <= mgmt_read;
      if (mgmt_read) begin
        mgmt_readdata <= next_readdata;
      end
    end
  end
endmodule : ksf_regs

// >>> verif/ksf_regs_properties.sv
// Purpose: port timing checks for the register bank
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every ksf_regs instance
module ksf_regs_properties
  import ksf_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] mgmt_address,
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  input wire logic [31:0] mgmt_writedata,
  input wire logic mgmt_readvalid,
  input wire logic tx_sm_in_an_state,
  input wire logic fec_enable,
  input wire logic fec_err_to_pcs,
  input wire logic fec_request_enable,
  input wire logic seq_reset_pulse,
  input wire logic tx_fec_error_pulse,
  input wire logic an_enable,
  input wire logic override_adv_enable,
  input wire logic an_tx_restart_pulse,
  input wire logic extended_next_page_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // decoded write strobes
  // ----------------------------------------------------------------
  logic wr_ctrl, wr_rst, inj_hit, wr_anc, rst_hit, np_hit;
  assign wr_ctrl = mgmt_write && mgmt_address == KSF_ADDR_SEQ_CTRL;
  assign wr_rst = wr_ctrl && mgmt_writedata[0];
  assign inj_hit = mgmt_write && mgmt_address == KSF_ADDR_FEC_INJ && mgmt_writedata[11];
  assign wr_anc = mgmt_write && mgmt_address == KSF_ADDR_AN_CTRL;
  assign rst_hit = mgmt_write && mgmt_address == KSF_ADDR_AN_CMD && mgmt_writedata[4];
  assign np_hit = mgmt_write && mgmt_address == KSF_ADDR_AN_CMD && mgmt_writedata[8];
  // lone reset write, then one-cycle pulse
  sequence s_lone_rst_wr;
    wr_rst ##1 !wr_ctrl;
  endsequence
  sequence s_one_cycle_pulse;
    seq_reset_pulse ##1 !seq_reset_pulse;
  endsequence
  property p_fec_fields;
    wr_ctrl |=> {fec_request_enable, fec_err_to_pcs, fec_enable} == $past(mgmt_writedata[18:16]);
  endproperty
  a_fec_fields: assert property (p_fec_fields) else $error("fec fields not loaded");
  property p_seq_pulse;
    s_lone_rst_wr |-> s_one_cycle_pulse;
  endproperty
  a_seq_pulse: assert property (p_seq_pulse) else $error("sequencer reset pulse bad");
  property p_seq_cause;
    seq_reset_pulse |-> $past(wr_rst);
  endproperty
  a_seq_cause: assert property (p_seq_cause) else $error("stray sequencer reset");
  property p_inject;
    inj_hit |=> tx_fec_error_pulse;
  endproperty
  a_inject: assert property (p_inject) else $error("inject pulse missing");
  property p_inject_cause;
    tx_fec_error_pulse |-> $past(inj_hit);
  endproperty
  a_inject_cause: assert property (p_inject_cause) else $error("stray inject pulse");
  property p_an_fields;
    wr_anc |=> an_enable == $past(mgmt_writedata[0]) &&
      override_adv_enable == $past(mgmt_writedata[5]);
  endproperty
  a_an_fields: assert property (p_an_fields) else $error("negotiation fields bad");
  property p_restart_gate;
    rst_hit && !tx_sm_in_an_state |=> !an_tx_restart_pulse;
  endproperty
  a_restart_gate: assert property (p_restart_gate) else $error("restart not gated");
  property p_restart_fire;
    rst_hit && tx_sm_in_an_state |=> an_tx_restart_pulse;
  endproperty
  a_restart_fire: assert property (p_restart_fire) else $error("restart missing");
  property p_next_page;
    np_hit |=> extended_next_page_ready;
  endproperty
  a_next_page: assert property (p_next_page) else $error("next page not flagged");
  property p_read_answer;
    mgmt_read |=> mgmt_readvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
endmodule : ksf_regs_properties

bind ksf_regs ksf_regs_properties #(.ADDR_W(ADDR_W)) u_props (.clk, .reset, .mgmt_address,
  .mgmt_write, .mgmt_read, .mgmt_writedata, .mgmt_readvalid, .tx_sm_in_an_state, .fec_enable,
  .fec_err_to_pcs, .fec_request_enable, .seq_reset_pulse, .tx_fec_error_pulse, .an_enable,
  .override_adv_enable, .an_tx_restart_pulse, .extended_next_page_ready);

// >>> verif/test_kr_sequencer_fec_an_control.sv
// Purpose: directed register test of the bank
// Assumes: default build parameters, 20 MHz clock
// Notes: inputs move 1 ns after the rising edge
module test_kr_sequencer_fec_an_control;
  timeunit 1ns;
  timeprecision 1ps;
  import ksf_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [10:0] addr = 11'h000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic rvalid;
  logic lrdy = 1'b0, tmo = 1'b0, rstrt = 1'b0, lt = 1'b0, in_an = 1'b0, sent = 1'b0;
  logic [5:0] mode = 6'h00;
  logic [13:0] ctl;
  int bad_count = 0;
  int checked = 0;
  always #25 clk = ~clk;
  ksf_regs dut (.clk(clk), .reset(reset), .mgmt_address(addr), .mgmt_write(wr_en),
    .mgmt_read(rd_en), .mgmt_writedata(wdata), .mgmt_readdata(rdata), .mgmt_readvalid(rvalid),
    .seq_link_ready(lrdy), .negotiation_timeout_flag_evt(tmo), .seq_an_restart_evt(rstrt),
    .training_timeout_flag(lt), .seq_reconfig_mode(mode), .tx_sm_in_an_state(in_an),
    .next_page_sent(sent), .fec_enable(ctl[0]), .fec_err_to_pcs(ctl[1]),
    .fec_request_enable(ctl[2]), .seq_reset_pulse(ctl[3]), .tx_fec_error_pulse(ctl[4]),
    .an_enable(ctl[5]), .user_base_page_sel(ctl[6]), .user_next_page_sel(ctl[7]),
    .local_remote_fault(ctl[8]), .force_tx_nonce(ctl[9]), .override_adv_enable(ctl[10]),
    .an_reset_pulse(ctl[11]), .an_tx_restart_pulse(ctl[12]),
    .extended_next_page_ready(ctl[13]));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    step;
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [10:0] a, input logic [31:0] exp);
    addr = a;
    rd_en = 1'b1;
    step;
    rd_en = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask : rd
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // bounded run length
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    chk({18'h0, ctl}, 32'h0000_0021);
    rd(KSF_ADDR_SEQ_CTRL, 32'h0001_0000);
    wr(KSF_ADDR_SEQ_CTRL, 32'h0006_0001);
    chk({18'h0, ctl}, 32'h0000_002E);
    step;
    chk({18'h0, ctl}, 32'h0000_0026);
    rd(KSF_ADDR_SEQ_CTRL, 32'h0006_0000);
    // timeout and restart together (set wins), sticky, then restart alone clears
    lrdy = 1'b1;
    lt = 1'b1;
    mode = 6'h2A;
    tmo = 1'b1;
    rstrt = 1'b1;
    step;
    tmo = 1'b0;
    rstrt = 1'b0;
    step;
    step;
    rd(KSF_ADDR_SEQ_STAT, 32'h0003_2A07);
    repeat (2) step;
    rd(KSF_ADDR_SEQ_STAT, 32'h0003_2A07);
    rstrt = 1'b1;
    step;
    rstrt = 1'b0;
    lrdy = 1'b0;
    lt = 1'b0;
    mode = 6'h15;
    repeat (2) step;
    rd(KSF_ADDR_SEQ_STAT, 32'h0003_1500);
    wr(KSF_ADDR_FEC_INJ, 32'hFFFF_FFFF);
    chk({31'h0, ctl[4]}, 32'h1);
    step;
    chk({31'h0, ctl[4]}, 32'h0);
    rd(KSF_ADDR_FEC_INJ, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(KSF_ADDR_AN_CTRL, 32'h1 << i);
      rd(KSF_ADDR_AN_CTRL, 32'h1 << i);
      chk({26'h0, ctl[10:5]}, 32'h1 << i);
    end
    wr(KSF_ADDR_AN_CTRL, 32'hFFFF_FFFF);
    rd(KSF_ADDR_AN_CTRL, 32'h0000_003F);
    wr(KSF_ADDR_AN_CMD, 32'h1);
    chk({31'h0, ctl[11]}, 32'h1);
    step;
    chk({31'h0, ctl[11]}, 32'h0);
    wr(KSF_ADDR_AN_CMD, 32'h10);
    chk({31'h0, ctl[12]}, 32'h0);
    step;
    in_an = 1'b1;
    wr(KSF_ADDR_AN_CMD, 32'h10);
    chk({31'h0, ctl[12]}, 32'h1);
    step;
    wr(KSF_ADDR_AN_CMD, 32'h100);
    chk({31'h0, ctl[13:12]}, 32'h2);
    rd(KSF_ADDR_AN_CMD, 32'h100);
    sent = 1'b1;
    step;
    sent = 1'b0;
    step;
    rd(KSF_ADDR_AN_CMD, 32'h0);
    wr(KSF_ADDR_RSVD_LO, 32'hFFFF_FFFF);
    rd(KSF_ADDR_RSVD_LO, 32'h0);
    step;
    rd(11'h7FF, 32'h0);
    end_of_test;
  end
endmodule : test_kr_sequencer_fec_an_control
